// [gbc_clock_select.sv]
// global clock and sync pin configuration for two groups of eight ports
// assumes an axi4-lite master; aclk is the master clock input of the device
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module gbc_clock_select
   import gbc_pkg::*;
(
   input wire logic aclk, // master clock, 2.048 or 1.544 MHz times 1, 2, 4 or 8
   input wire logic aresetn, // synchronous reset, active low
   input wire logic [15:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // write strobes
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic [15:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read data valid
   input wire logic s_axi_rready, // read data ready
   input wire logic [15:0] line_clk, // recovered line clocks, ports 1 to 16
   input wire logic ref_clk_pin_i, // reference_clock_pin level in
   output logic ref_clk_pin_o, // reference_clock_pin level out
   output logic ref_clk_pin_oe, // reference_clock_pin drive enable
   input wire logic backplane_clock_one, // generated backplane clock, group low
   input wire logic backplane_clock_two, // generated backplane clock, group high
   input wire logic [1:0] system_sync_gen, // system sync made per group
   input wire logic [15:0] port_frame_sync_o, // per-port frame sync from framers
   input wire logic [15:0] port_transmit_io_control, // per-port sync direction, 1 out
   input wire logic [15:0] sync_pin_i, // shared sync pins in
   output logic [15:0] sync_pin_o, // shared sync pins out
   output logic [15:0] sync_pin_oe, // shared sync pins drive enable
   output logic [15:0] port_frame_sync_in, // pin level to framers
   output logic [15:0] system_sync_in, // pin level to system sync logic
   input wire logic [15:0] rx_sys_clk_pin, // per-port receive system clock pins
   input wire logic [15:0] tx_sys_clk_pin, // per-port transmit system clock pins
   input wire logic [15:0] tx_line_clk_pin, // per-port transmit clock pins
   output logic [15:0] rx_sys_clk, // routed receive system clocks
   output logic [15:0] tx_sys_clk, // routed transmit system clocks
   output logic [15:0] tx_line_clk, // routed transmit clocks
   output logic [1:0] bp_ref, // selected backplane reference per group
   output logic [1:0] backplane_reference_rate, // 0 2.048 MHz, 1 1.544 MHz
   output logic master_base_rate, // 0 2.048 MHz family, 1 1.544 MHz family
   output logic [1:0] master_period_scale, // master clock multiple code
   output logic clock_out_pin // clock-out pin
);
   // ==========================================================
   // register bus
   logic [7:0] regs_r [REG_COUNT];
   logic aw_held_r;
   logic w_held_r;
   logic [15:0] aw_addr_r;
   logic [7:0] w_data_r;
   logic w_lane_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic rvalid_r;
   logic [7:0] rdata_r;
   logic [1:0] rresp_r;
   logic wr_do;
   logic [2:0] wr_sel;
   logic [2:0] rd_sel;
   logic aw_fire;
   logic w_fire;
   logic ar_fire;

   // byte address to register slot; unaligned or unmapped gives none
   function automatic logic [2:0] reg_slot(input logic [15:0] addr);
      logic [2:0] s;
      s = REG_NONE;
      for (int i = 0; i < REG_COUNT; i++) begin
         if (addr == {REG_INDEX[i][13:0], 2'b00}) begin
            s = 3'(i);
         end
      end
      return s;
   endfunction : reg_slot

   // handshakes: one write and one read at a time
   assign s_axi_awready = !aw_held_r && !bvalid_r;
   assign s_axi_wready = !w_held_r && !bvalid_r;
   assign s_axi_arready = !rvalid_r;
   assign aw_fire = s_axi_awvalid && s_axi_awready;
   assign w_fire = s_axi_wvalid && s_axi_wready;
   assign ar_fire = s_axi_arvalid && s_axi_arready;
   assign wr_do = aw_held_r && w_held_r && !bvalid_r;
   assign wr_sel = reg_slot(aw_addr_r);
   assign rd_sel = reg_slot(s_axi_araddr);
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rresp = rresp_r;
   assign s_axi_rdata = {24'h000000, rdata_r};

   // address and data are caught in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         aw_addr_r <= 16'h0000;
         w_data_r <= 8'h00;
         w_lane_r <= 1'b0;
      end else begin
         if (aw_fire) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end else if (wr_do) begin
            aw_held_r <= 1'b0;
         end
         if (w_fire) begin
            w_held_r <= 1'b1;
            w_data_r <= s_axi_wdata[7:0];
            w_lane_r <= s_axi_wstrb[0];
         end else if (wr_do) begin
            w_held_r <= 1'b0;
         end
      end
   end

   // write response one cycle after both halves are held
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
      end else if (wr_do) begin
         bvalid_r <= 1'b1;
         bresp_r <= (wr_sel == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bready) begin
         bvalid_r <= 1'b0;
      end
   end

   // read data one cycle after the address is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r <= 1'b0;
         rdata_r <= 8'h00;
         rresp_r <= RESP_OKAY;
      end else if (ar_fire) begin
         rvalid_r <= 1'b1;
         rdata_r <= (rd_sel == REG_NONE) ? 8'h00 : regs_r[rd_sel];
         rresp_r <= (rd_sel == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end

   // registers reset to zero, read back
   for (genvar g = 0; g < REG_COUNT; g++) begin : g_reg
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            regs_r[g] <= REG_RESET;
         end else if (wr_do && w_lane_r && wr_sel == 3'(g)) begin
            regs_r[g] <= w_data_r & REG_MASK[g];
         end
      end
   end

   // ==========================================================
   // master clock and reference rates
   logic [16:0] mclk_khz;
   logic [1:0] mclk_ref;
   logic [1:0] drive_pin;
   logic [3:0] eff_code [2];
   logic [3:0] ref_code [2];
   logic [7:0] clk_reg [2];

   assign clk_reg[0] = regs_r[REG_CLK_LO];
   // same reference select and rate encoding for ports 9 to 16; base rate and scale bits exist in group low only
   assign clk_reg[1] = regs_r[REG_CLK_HI];
   assign master_base_rate = regs_r[REG_CLK_LO][BASE_RATE_BIT];
   assign master_period_scale = regs_r[REG_CLK_LO][SCALE_LSB +: 2];
   assign mclk_khz = gbc_mclk_khz(master_base_rate, master_period_scale);

   // per group: derived reference and source selection
   for (genvar g = 0; g < 2; g++) begin : g_grp
      assign ref_code[g] = clk_reg[g][REF_SEL_LSB +: 4];
      assign backplane_reference_rate[g] = clk_reg[g][REF_RATE_BIT];

      // derived reference runs at the rate the rate bit declares when the master clock is at least twice it, else at aclk/2
      gbc_frac_div u_mdiv (
         .aclk(aclk),
         .aresetn(aresetn),
         .num((backplane_reference_rate[g] ? KHZ_1544 : KHZ_2048) << 1),
         .den(mclk_khz),
         .clk_o(mclk_ref[g]),
         .tick_o()
      );

      gbc_group_ref u_ref (
         .aclk(aclk),
         .aresetn(aresetn),
         .code(ref_code[g]),
         .line_clk(line_clk[g*8 +: 8]),
         .mclk_ref(mclk_ref[g]),
         .ext_ref(ref_clk_pin_i),
         .bp_ref(bp_ref[g]),
         .drive_pin(drive_pin[g]),
         .eff_code(eff_code[g])
      );
   end

   // shared reference pin; group low wins when both drive
   assign ref_clk_pin_oe = |drive_pin;
   assign ref_clk_pin_o = drive_pin[0] ? bp_ref[0] : bp_ref[1];

   gbc_frac_div u_clock_out_pin (
      .aclk(aclk),
      .aresetn(aresetn),
      .num(gbc_clock_out_pin_khz(regs_r[REG_ROUTE_LO][CLOCK_OUT_PIN_LSB +: 4]) << 1),
      .den(mclk_khz),
      .clk_o(clock_out_pin),
      .tick_o()
   );

   // ==========================================================
   // sync pins and clock routing
   logic [15:0] sync_o_nxt;
   logic [15:0] sync_oe_nxt;
   logic [15:0] fs_in_nxt;
   logic [15:0] ss_in_nxt;
   logic [15:0] rx_nxt;
   logic [15:0] tx_nxt;
   logic [15:0] tl_nxt;
   logic [1:0] bp_clk;

   assign bp_clk = {backplane_clock_two, backplane_clock_one};

   for (genvar p = 0; p < 16; p++) begin : g_port
      localparam int unsigned GRP = p / 8;
      logic sys_fn;
      logic sys_out;
      logic [7:0] rt;
      assign sys_fn = regs_r[GRP == 0 ? REG_SYNC_LO : REG_SYNC_HI][SYNC_FUNC_BIT];
      assign sys_out = regs_r[GRP == 0 ? REG_SYNC_LO : REG_SYNC_HI][SYNC_DIR_BIT];
      assign rt = regs_r[GRP == 0 ? REG_ROUTE_LO : REG_ROUTE_HI];
      // pin function, per-port direction, global direction
      assign sync_oe_nxt[p] = sys_fn ? sys_out : port_transmit_io_control[p];
      assign sync_o_nxt[p] = sys_fn ? system_sync_gen[GRP] : port_frame_sync_o[p];
      assign fs_in_nxt[p] = !sys_fn && sync_pin_i[p];
      assign ss_in_nxt[p] = sys_fn && sync_pin_i[p];
      assign rx_nxt[p] = rt[RX_SYS_BIT] ? bp_clk[GRP] : rx_sys_clk_pin[p];
      assign tx_nxt[p] = rt[TX_SYS_BIT] ? bp_clk[GRP] : tx_sys_clk_pin[p];
      assign tl_nxt[p] = rt[TX_LINE_BIT] ? ref_clk_pin_i : tx_line_clk_pin[p];
   end

   // pin and routing outputs from flops
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync_pin_o <= 16'h0000;
         sync_pin_oe <= 16'h0000;
         port_frame_sync_in <= 16'h0000;
         system_sync_in <= 16'h0000;
         rx_sys_clk <= 16'h0000;
         tx_sys_clk <= 16'h0000;
         tx_line_clk <= 16'h0000;
      end else begin
         sync_pin_o <= sync_o_nxt;
         sync_pin_oe <= sync_oe_nxt;
         port_frame_sync_in <= fs_in_nxt;
         system_sync_in <= ss_in_nxt;
         rx_sys_clk <= rx_nxt;
         tx_sys_clk <= tx_nxt;
         tx_line_clk <= tl_nxt;
      end
   end

   // ==========================================================
   // assertions
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_port_sync_dir: assert property (
      !regs_r[REG_SYNC_LO][SYNC_FUNC_BIT] |=> sync_pin_oe[0] == $past(port_transmit_io_control[0]))
      else $error("sync pin direction ignores per-port control");
   a_sys_sync_dir: assert property (
      regs_r[REG_SYNC_HI][SYNC_FUNC_BIT] |=>
      sync_pin_oe[9] == $past(regs_r[REG_SYNC_HI][SYNC_DIR_BIT]))
      else $error("system sync direction wrong");
   a_sync_func_out: assert property (
      regs_r[REG_SYNC_LO][SYNC_FUNC_BIT] |=> sync_pin_o[2] == $past(system_sync_gen[0]))
      else $error("sync pin does not carry system sync");
   a_ref_pin_out: assert property (
      ref_code[0] == REF_CODE_MCLK |=> ref_clk_pin_oe)
      else $error("reference pin not driven for derived reference");
   a_ref_pin_in: assert property (
      ref_code[0] == REF_CODE_EXT && ref_code[1] == REF_CODE_EXT |=> !ref_clk_pin_oe
      ##0 bp_ref[1] == $past(ref_clk_pin_i))
      else $error("external reference misused");
   a_line_ref_sel: assert property (
      ref_code[1] == 4'h3 |=> bp_ref[1] == $past(line_clk[11]))
      else $error("wrong recovered clock selected");
   a_bad_code_hold: assert property (
      ref_code[0] > REF_CODE_EXT |=> eff_code[0] == $past(eff_code[0]))
      else $error("undefined code changed the reference");
   a_rx_route: assert property (
      regs_r[REG_ROUTE_LO][RX_SYS_BIT] |=> rx_sys_clk[5] == $past(backplane_clock_one))
      else $error("receive system clock not from backplane clock");
   a_tx_line_route: assert property (
      !regs_r[REG_ROUTE_HI][TX_LINE_BIT] |=> tx_line_clk[12] == $past(tx_line_clk_pin[12]))
      else $error("transmit clock not from its own pin");
   a_bresp_hold: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");

   c_mclk_ref: cover property (ref_code[0] == REF_CODE_MCLK ##4 ref_clk_pin_oe);
   c_ext_ref: cover property (ref_code[1] == REF_CODE_EXT && !ref_clk_pin_oe);
   c_sys_sync: cover property (regs_r[REG_SYNC_HI] == 8'h03);
   c_write_read: cover property (s_axi_bvalid ##[1:10] s_axi_rvalid);
endmodule : gbc_clock_select

// [gbc_far_end.sv]
// line side model: recovered line clocks and the external reference source
// assumes the bench sets the wanted levels; pins settle within the same cycle
`timescale 1ns/1ps
module gbc_far_end (
   input wire logic [15:0] line_lvl, // wanted recovered clock levels
   input wire logic ext_lvl, // external reference source level
   input wire logic ref_clk_pin_o, // device drive value on the reference pin
   input wire logic ref_clk_pin_oe, // device drive enable on the reference pin
   output logic [15:0] line_clk, // recovered line clocks to the device
   output logic ref_clk_pin_i // resolved reference pin level
);
   // ===========================================
   // pin resolution
   // static levels keep the check free of phase questions
   assign line_clk = line_lvl;
   // device drive wins; the external source backs off while driven
   assign ref_clk_pin_i = ref_clk_pin_oe ? ref_clk_pin_o : ext_lvl;
endmodule : gbc_far_end

// [gbc_frac_div.sv]
// fractional divider: toggles its output so that it runs at half of num/den of aclk
// assumes num and den in the same unit; num above den saturates at aclk/2
`timescale 1ns/1ps
module gbc_frac_div
   import gbc_pkg::*;
(
   input wire logic aclk, // master clock
   input wire logic aresetn, // synchronous reset, active low
   input wire logic [16:0] num, // twice the wanted rate
   input wire logic [16:0] den, // master clock rate
   output logic clk_o, // divided clock level
   output logic tick_o // one-cycle enable at each edge of clk_o
);
   logic [17:0] acc_r;
   logic [17:0] acc_nxt;
   logic [17:0] sum;
   logic [16:0] step;
   logic wrap;
   logic clk_r;

   // clamp the step: a rate above half the master clock cannot be made
   assign step = (num > den) ? den : num;
   assign sum = acc_r + {1'b0, step};
   assign wrap = sum >= {1'b0, den};
   assign acc_nxt = wrap ? (sum - {1'b0, den}) : sum;
   assign clk_o = clk_r;

   // accumulator and output toggle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         acc_r <= 18'h00000;
         clk_r <= 1'b0;
         tick_o <= 1'b0;
      end else begin
         acc_r <= acc_nxt;
         clk_r <= clk_r ^ wrap;
         tick_o <= wrap;
      end
   end
endmodule : gbc_frac_div

// [gbc_group_ref.sv]
// backplane reference selection for one group of eight ports
// assumes line clocks and the external reference are synchronous to aclk
`timescale 1ns/1ps
module gbc_group_ref
   import gbc_pkg::*;
(
   input wire logic aclk, // master clock
   input wire logic aresetn, // synchronous reset, active low
   input wire logic [3:0] code, // backplane_reference_select field
   input wire logic [7:0] line_clk, // recovered line clocks of the group
   input wire logic mclk_ref, // reference derived from the master clock
   input wire logic ext_ref, // level on reference_clock_pin
   output logic bp_ref, // selected reference level
   output logic drive_pin, // high while the reference pin must be driven
   output logic [3:0] eff_code // code in force
);
   logic [3:0] eff_r;
   logic [3:0] eff_w;
   logic legal;

   assign legal = code <= REF_CODE_EXT;
   assign eff_w = legal ? code : eff_r;
   assign eff_code = eff_r;

   // selection registered to keep the reference glitch free
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         eff_r <= 4'h0;
         bp_ref <= 1'b0;
         drive_pin <= 1'b0;
      end else begin
         eff_r <= eff_w;
         bp_ref <= (eff_w == REF_CODE_MCLK) ? mclk_ref :
                   (eff_w == REF_CODE_EXT) ? ext_ref : line_clk[eff_w[2:0]];
         drive_pin <= eff_w == REF_CODE_MCLK;
      end
   end
endmodule : gbc_group_ref

// [gbc_pkg.sv]
// constants, register map and rate tables of the global backplane clock select block
// assumes a 32-bit axi4-lite master and aclk acting as the master clock input
package gbc_pkg;

   // ==========================================================
   // register map (printed offsets are indices, byte address = 4 x index)
   localparam int unsigned ADDR_W = 16;
   localparam int unsigned REG_COUNT = 6;
   localparam logic [2:0] REG_NONE = 3'h7;
   localparam logic [2:0] REG_SYNC_LO = 3'h0;
   localparam logic [2:0] REG_CLK_LO = 3'h1;
   localparam logic [2:0] REG_ROUTE_LO = 3'h2;
   localparam logic [2:0] REG_SYNC_HI = 3'h3;
   localparam logic [2:0] REG_CLK_HI = 3'h4;
   localparam logic [2:0] REG_ROUTE_HI = 3'h5;
   // sync_pin_control_group_low, clock_control_group_low, clock_routing_group_low,
   // sync_pin_control_group_high, clock_control_group_high, clock_routing_group_high
   localparam logic [15:0] REG_INDEX [REG_COUNT] = '{16'h00f2, 16'h00f3, 16'h00f4,
                                                     16'h20f2, 16'h20f3, 16'h20f4};
   // bits that hold state; the rest read as zero
   localparam logic [7:0] REG_MASK [REG_COUNT] = '{8'h03, 8'hff, 8'h7f, 8'h03, 8'hf8, 8'h70};
   localparam logic [7:0] REG_RESET = 8'h00;

   // ==========================================================
   // field positions
   localparam int unsigned SYNC_FUNC_BIT = 0;
   localparam int unsigned SYNC_DIR_BIT = 1;
   localparam int unsigned REF_SEL_LSB = 4;
   localparam int unsigned REF_RATE_BIT = 3;
   localparam int unsigned BASE_RATE_BIT = 2;
   localparam int unsigned SCALE_LSB = 0;
   localparam int unsigned RX_SYS_BIT = 6;
   localparam int unsigned TX_SYS_BIT = 5;
   localparam int unsigned TX_LINE_BIT = 4;
   localparam int unsigned CLOCK_OUT_PIN_LSB = 0;

   // ==========================================================
   // reference-select codes
   localparam logic [3:0] REF_CODE_MCLK = 4'h8;
   localparam logic [3:0] REF_CODE_EXT = 4'h9;

   // ==========================================================
   // rates in khz
   localparam logic [16:0] KHZ_2048 = 17'h00800;
   localparam logic [16:0] KHZ_1544 = 17'h00608;

   // ==========================================================
   // axi responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // master clock rate: base rate scaled by 1, 2, 4 or 8
   function automatic logic [16:0] gbc_mclk_khz(input logic base, input logic [1:0] scale);
      logic [16:0] b;
      b = base ? KHZ_1544 : KHZ_2048;
      return b << scale;
   endfunction : gbc_mclk_khz

   // clock-out pin rate per select code
   function automatic logic [16:0] gbc_clock_out_pin_khz(input logic [3:0] code);
      logic [16:0] k;
      unique case (code)
         4'h0: k = 17'h00800;
         4'h1: k = 17'h01000;
         4'h2: k = 17'h02000;
         4'h3: k = 17'h04000;
         4'h4: k = 17'h00608;
         4'h5: k = 17'h00c10;
         4'h6: k = 17'h01820;
         4'h7: k = 17'h03040;
         4'h8: k = 17'h00600;
         4'h9: k = 17'h00c00;
         4'ha: k = 17'h01800;
         4'hb: k = 17'h03000;
         4'hc: k = 17'h00020;
         4'hd: k = 17'h00040;
         4'he: k = 17'h00080;
         4'hf: k = 17'h00100;
      endcase
      return k;
   endfunction : gbc_clock_out_pin_khz

endpackage : gbc_pkg

// [tb_gbc_clock_select.sv]
// self-checking bench for the global clock select block
// assumes the far_end model on the line side and an axi4-lite master here
`timescale 1ns/1ps
module tb_gbc_clock_select;
   import gbc_pkg::*;
   logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, ext_lvl = 0, backplane_clock_one = 0;
   logic backplane_clock_two = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, ref_clk_pin_i, ref_clk_pin_o, ref_clk_pin_oe, master_base_rate;
   logic clock_out_pin;
   logic [1:0] s_axi_bresp, s_axi_rresp, bp_ref, backplane_reference_rate, master_period_scale;
   logic [1:0] system_sync_gen = 0;
   logic [3:0] s_axi_wstrb = 4'h1;
   logic [15:0] s_axi_awaddr = 0, s_axi_araddr = 0, line_lvl = 0, pin_lvl = 16'h3c5a;
   logic [15:0] port_frame_sync_o = 0, sync_pin_i = 0, port_transmit_io_control = 16'h00a5;
   logic [15:0] line_clk, sync_pin_o, sync_pin_oe, port_frame_sync_in, system_sync_in;
   logic [15:0] rx_sys_clk, tx_sys_clk, tx_line_clk;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata;
   logic [15:0] adr [6] = '{16'h03c8, 16'h03cc, 16'h03d0, 16'h83c8, 16'h83cc, 16'h83d0};
   int n_errors = 0, checks_done = 0, cyc = 0;

   gbc_clock_select dut (.*, .rx_sys_clk_pin(pin_lvl), .tx_sys_clk_pin(pin_lvl),
      .tx_line_clk_pin(pin_lvl));
   gbc_far_end far (.*);

   // ===========================================
   // clock, reset and hang guard
   initial begin
      forever #5 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         tally_and_finish();
      end
   end

   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         n_errors++;
         $display("MISMATCH %s exp %h seen %h", nm, e, s);
      end
   endtask : chk

   task automatic w4;
      repeat (4) @(posedge aclk);
   endtask : w4

   // ===========================================
   // bus tasks: readies sampled at the falling edge stay put until the rising one
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      logic ta, tw, bv;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      bv = 0;
      while (!bv) begin
         @(negedge aclk);
         ta = s_axi_awready && s_axi_awvalid;
         tw = s_axi_wready && s_axi_wvalid;
         bv = s_axi_bvalid;
         if (bv) chk("bresp", s_axi_bresp, {30'h0, (a[1:0] == 0) ? RESP_OKAY : RESP_SLVERR});
         @(posedge aclk);
         if (ta) s_axi_awvalid <= 0;
         if (tw) s_axi_wvalid <= 0;
         if (bv) s_axi_bready <= 0;
      end
   endtask : wr

   task automatic rd(input logic [15:0] a, input logic [7:0] e, input logic [1:0] er);
      logic t, rv;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      rv = 0;
      while (!rv) begin
         @(negedge aclk);
         t = s_axi_arready && s_axi_arvalid;
         rv = s_axi_rvalid;
         if (rv) begin
            chk("rdata", s_axi_rdata, {24'h0, e});
            chk("rresp", s_axi_rresp, {30'h0, er});
         end
         @(posedge aclk);
         if (t) s_axi_arvalid <= 0;
         if (rv) s_axi_rready <= 0;
      end
   endtask : rd

   // ===========================================
   // scenarios
   task automatic t_regs;
      for (int i = 0; i < 6; i++) begin
         rd(adr[i], 8'h00, RESP_OKAY);
         wr(adr[i], 8'hff);
         rd(adr[i], REG_MASK[i], RESP_OKAY);
         wr(adr[i], 8'h00);
      end
      rd(16'h03d4, 8'h00, RESP_SLVERR);
   endtask : t_regs

   task automatic t_ref;
      logic pin_seen;
      for (int c = 0; c < 8; c++) begin
         // rate bit zero agrees with e1 line clocks
         wr(16'h03cc, {c[3:0], 4'h0});
         wr(16'h83cc, {c[3:0], 4'h0});
         line_lvl <= (16'h1 << c) | (16'h100 << c);
         w4();
         chk("bp_ref one", bp_ref, 2'h3);
         line_lvl <= ~((16'h1 << c) | (16'h100 << c));
         w4();
         chk("bp_ref zero", bp_ref, 2'h0);
      end
      wr(16'h03cc, {REF_CODE_MCLK, 4'h0});
      w4();
      chk("ref oe", ref_clk_pin_oe, 1);
      // derived reference saturates, toggles each cycle
      @(negedge aclk);
      pin_seen = ref_clk_pin_o;
      @(negedge aclk);
      chk("ref toggles", ref_clk_pin_o, !pin_seen);
      wr(16'h03cc, {REF_CODE_EXT, 4'h8});
      wr(16'h83cc, {REF_CODE_EXT, 4'h8});
      ext_lvl <= 1;
      backplane_clock_one <= 1;
      w4();
      chk("ref oe", ref_clk_pin_oe, 0);
      chk("bp_ref ext", bp_ref[0], 1);
      chk("bp_ref ext hi", bp_ref[1], 1);
      chk("ref rate", backplane_reference_rate, 2'h3);
   endtask : t_ref

   task automatic t_route;
      wr(16'h03d0, 8'h70);
      wr(16'h83d0, 8'h70);
      w4();
      chk("rx sys", rx_sys_clk, 16'h00ff);
      chk("tx sys", tx_sys_clk, 16'h00ff);
      chk("tx line", tx_line_clk, 16'hffff);
      wr(16'h03d0, 8'h00);
      wr(16'h83d0, 8'h00);
      w4();
      chk("rx pin", rx_sys_clk, pin_lvl);
      chk("tx line pin", tx_line_clk, pin_lvl);
      // undefined code keeps the external reference in force
      wr(16'h03cc, 8'ha7);
      ext_lvl <= 0;
      w4();
      chk("bp_ref kept", bp_ref[0], 0);
      chk("ref oe", ref_clk_pin_oe, 0);
      chk("base", master_base_rate, 1);
      chk("scale", master_period_scale, 2'h3);
      rd(16'h03cc, 8'ha7, RESP_OKAY);
   endtask : t_route

   task automatic t_sync;
      port_frame_sync_o <= 16'h1234;
      sync_pin_i <= 16'h0ff0;
      system_sync_gen <= 2'b10;
      w4();
      chk("sync oe tio", sync_pin_oe[7:0], 8'ha5);
      chk("sync out fs", sync_pin_o, 16'h1234);
      chk("fs in", port_frame_sync_in, 16'h0ff0);
      chk("ss in idle", system_sync_in, 16'h0000);
      wr(16'h03c8, 8'h01);
      w4();
      chk("sync oe in", sync_pin_oe[7:0], 8'h00);
      wr(16'h03c8, 8'h03);
      // system sync as with elastic stores on
      wr(16'h83c8, 8'h03);
      w4();
      chk("sync oe out", sync_pin_oe, 16'hffff);
      chk("sync out ss", sync_pin_o, 16'hff00);
      chk("ss in", system_sync_in, 16'h0ff0);
      chk("fs in off", port_frame_sync_in, 16'h0000);
   endtask : t_sync

   // clock-out at 32 khz: master 2048 khz toggles every 32 cycles, 4096 khz every 64
   task automatic t_clock_out_pin;
      int n;
      logic last;
      wr(16'h03d0, 8'h0c);
      for (int s = 0; s < 2; s++) begin
         wr(16'h03cc, {7'h00, s[0]});
         // divider may wrap every cycle until its accumulator drops below the master clock rate less the step
         w4();
         w4();
         @(negedge aclk);
         last = clock_out_pin;
         n = 0;
         repeat (64) begin
            @(negedge aclk);
            if (clock_out_pin !== last) n++;
            last = clock_out_pin;
         end
         chk("clock_out_pin edges", n, 2 - s);
      end
   endtask : t_clock_out_pin

   task automatic tally_and_finish;
      if (n_errors == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : tally_and_finish

   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1;
      t_regs();
      t_sync();
      t_ref();
      t_route();
      t_clock_out_pin();
      tally_and_finish();
   end
endmodule : tb_gbc_clock_select
